// ===== rtl/aesa_cnt_if.sv
// Interface between the controller and its pulse timer.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface aesa_cnt_if;
	logic       load;
	logic [3:0] count;
	logic       done;
	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface : aesa_cnt_if
`default_nettype wire

// ===== rtl/aesa_consts.svh
// Constants for the asynchronous ECC static memory controller.
// Assumes a 100 MHz controller clock.
`ifndef AESA_CONSTS_SVH
`define AESA_CONSTS_SVH
`define AESA_CLK_PERIOD_PS 10000
`define AESA_T_RC_PS       10000
`define AESA_T_PWE_PS      7000
`define AESA_T_DOE_PS      10000
`define AESA_RD_CYC        ((`AESA_T_DOE_PS + `AESA_CLK_PERIOD_PS - 1) / `AESA_CLK_PERIOD_PS + 1)
`define AESA_WR_CYC        ((`AESA_T_PWE_PS + `AESA_CLK_PERIOD_PS - 1) / `AESA_CLK_PERIOD_PS)
`define AESA_ADDR_W        20
`define AESA_DATA_W        16
`define AESA_LANE_LO       0
`define AESA_LANE_HI       1
`endif

// ===== rtl/aesa_ctrl.sv
// Host-side controller driving an asynchronous 1M x 16 ECC static memory.
// Assumes memory pins registered here; bidirectional data split in/out/enable.
`include "aesa_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module aesa_ctrl
#(
	parameter int ADDR_W = `AESA_ADDR_W,
	parameter int DATA_W = `AESA_DATA_W
)
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_req,
	input  wire logic                   i_we,
	input  wire logic [ADDR_W-1:0]      i_addr,
	input  wire logic [DATA_W-1:0]      i_wdata,
	input  wire aesa_pkg::aesa_lanes_type i_lanes,
	output logic                        o_busy,
	output logic                        o_done,
	output logic [DATA_W-1:0]           o_rdata,
	output logic                        o_err,
	output logic                        o_chip_select_low_active,
	output logic                        o_chip_select_high_active,
	output logic                        o_oe_n,
	output logic                        o_we_n,
	output logic                        o_lower_lane_enable_n,
	output logic                        o_upper_lane_enable_n,
	output logic [ADDR_W-1:0]           o_addr,
	output logic [DATA_W-1:0]           o_dq,
	output logic                        o_dq_oe_n,
	input  wire logic [DATA_W-1:0]      i_dq,
	input  wire logic                   i_err
);
	import aesa_pkg::*;

	localparam logic [3:0] RD_CYC = 4'(`AESA_RD_CYC);
	localparam logic [3:0] WR_CYC = 4'(`AESA_WR_CYC);

	// Keep only bytes of enabled lanes, clear the rest
	function automatic logic [DATA_W-1:0] lane_mask(input logic [DATA_W-1:0] d,
		input aesa_lanes_type l);
		logic [DATA_W-1:0] r;
		r = d;
		if (!l[`AESA_LANE_LO])
			r[DATA_W/2-1:0] = '0;
		if (!l[`AESA_LANE_HI])
			r[DATA_W-1:DATA_W/2] = '0;
		return r;
	endfunction : lane_mask

	aesa_cnt_if cnt ();
	aesa_timer u_timer (.i_clk(i_clk), .i_rst(i_rst), .cnt(cnt));

	aesa_state_type    state_reg, state_next;
	logic              wr_reg, wr_next;
	aesa_lanes_type    lanes_reg, lanes_next;
	logic              busy_reg, busy_next;
	logic              done_reg, done_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic              err_reg, err_next;
	logic              cs_n_reg, cs_n_next;
	logic              oe_n_reg, oe_n_next;
	logic              we_n_reg, we_n_next;
	logic              ble_n_reg, ble_n_next;
	logic              bhe_n_reg, bhe_n_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] dq_reg, dq_next;
	logic              dq_oe_n_reg, dq_oe_n_next;

	always_comb
	begin
		state_next   = state_reg;
		wr_next      = wr_reg;
		lanes_next   = lanes_reg;
		busy_next    = busy_reg;
		done_next    = 1'b0;
		rdata_next   = rdata_reg;
		err_next     = err_reg;
		cs_n_next    = cs_n_reg;
		oe_n_next    = oe_n_reg;
		we_n_next    = we_n_reg;
		ble_n_next   = ble_n_reg;
		bhe_n_next   = bhe_n_reg;
		addr_next    = addr_reg;
		dq_next      = dq_reg;
		dq_oe_n_next = dq_oe_n_reg;
		cnt.load     = 1'b0;
		cnt.count    = 4'h0;
		unique case (state_reg)
			AESA_IDLE:
			begin
				// Requests with no lane selected are dropped as nothing would happen
				if (i_req && (i_lanes != 2'h0))
				begin
					state_next = AESA_SETUP;
					busy_next  = 1'b1;
					wr_next    = i_we;
					lanes_next = i_lanes;
					addr_next  = i_addr;
					dq_next    = i_wdata;
				end
			end
			AESA_SETUP:
			begin
				// Address has been stable a cycle; now select and strobe together
				cs_n_next  = 1'b0;
				ble_n_next = !lanes_reg[`AESA_LANE_LO];
				bhe_n_next = !lanes_reg[`AESA_LANE_HI];
				cnt.load   = 1'b1;
				if (wr_reg)
				begin
					oe_n_next    = 1'b1;
					we_n_next    = 1'b0;
					dq_oe_n_next = 1'b0;
					cnt.count    = WR_CYC;
					state_next   = AESA_WR;
				end
				else
				begin
					we_n_next    = 1'b1;
					oe_n_next    = 1'b0;
					dq_oe_n_next = 1'b1;
					cnt.count    = RD_CYC;
					state_next   = AESA_RD;
				end
			end
			AESA_RD:
			begin
				if (cnt.done)
				begin
					rdata_next = lane_mask(i_dq, lanes_reg);
					err_next   = i_err;
					oe_n_next  = 1'b1;
					cs_n_next  = 1'b1;
					ble_n_next = 1'b1;
					bhe_n_next = 1'b1;
					state_next = AESA_END;
				end
			end
			AESA_WR:
			begin
				if (cnt.done)
				begin
					// Write enable rises first, data held one more cycle
					we_n_next  = 1'b1;
					state_next = AESA_END;
				end
			end
			AESA_END:
			begin
				cs_n_next    = 1'b1;
				ble_n_next   = 1'b1;
				bhe_n_next   = 1'b1;
				dq_oe_n_next = 1'b1;
				if (!wr_reg)
					err_next = err_reg;
				else
					err_next = 1'b0;
				busy_next  = 1'b0;
				done_next  = 1'b1;
				state_next = AESA_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_reg   <= AESA_IDLE;
			wr_reg      <= 1'b0;
			lanes_reg   <= 2'h0;
			busy_reg    <= 1'b0;
			done_reg    <= 1'b0;
			rdata_reg   <= '0;
			err_reg     <= 1'b0;
			cs_n_reg    <= 1'b1;
			oe_n_reg    <= 1'b1;
			we_n_reg    <= 1'b1;
			ble_n_reg   <= 1'b1;
			bhe_n_reg   <= 1'b1;
			addr_reg    <= '0;
			dq_reg      <= '0;
			dq_oe_n_reg <= 1'b1;
		end
		else
		begin
			state_reg   <= state_next;
			wr_reg      <= wr_next;
			lanes_reg   <= lanes_next;
			busy_reg    <= busy_next;
			done_reg    <= done_next;
			rdata_reg   <= rdata_next;
			err_reg     <= err_next;
			cs_n_reg    <= cs_n_next;
			oe_n_reg    <= oe_n_next;
			we_n_reg    <= we_n_next;
			ble_n_reg   <= ble_n_next;
			bhe_n_reg   <= bhe_n_next;
			addr_reg    <= addr_next;
			dq_reg      <= dq_next;
			dq_oe_n_reg <= dq_oe_n_next;
		end
	end

	// Dual-select parts see the high-active select as the inverse of the low one
	logic cs_hi_reg;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cs_hi_reg <= 1'b0;
		else
			cs_hi_reg <= !cs_n_next;
	end

	assign o_busy                    = busy_reg;
	assign o_done                    = done_reg;
	assign o_rdata                   = rdata_reg;
	assign o_err                     = err_reg;
	assign o_chip_select_low_active  = cs_n_reg;
	assign o_chip_select_high_active = cs_hi_reg;
	assign o_oe_n                    = oe_n_reg;
	assign o_we_n                    = we_n_reg;
	assign o_lower_lane_enable_n     = ble_n_reg;
	assign o_upper_lane_enable_n     = bhe_n_reg;
	assign o_addr                    = addr_reg;
	assign o_dq                      = dq_reg;
	assign o_dq_oe_n                 = dq_oe_n_reg;
endmodule : aesa_ctrl
`default_nettype wire

// ===== rtl/aesa_pkg.sv
// Types for the asynchronous ECC static memory controller.
// Assumes aesa_consts.svh is on the include path.
package aesa_pkg;
	typedef enum logic [4:0] {
		AESA_IDLE  = 5'h01,
		AESA_SETUP = 5'h02,
		AESA_RD    = 5'h04,
		AESA_WR    = 5'h08,
		AESA_END   = 5'h10
	} aesa_state_type;
	typedef logic [1:0] aesa_lanes_type;
endpackage : aesa_pkg

// ===== rtl/aesa_timer.sv
// Down-counter timing read and write strobe widths.
// Assumes synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module aesa_timer
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	aesa_cnt_if.tmr   cnt
);
	logic [3:0] left_reg;
	logic [3:0] left_next;
	always_comb
	begin
		left_next = left_reg;
		if (cnt.load)
			left_next = cnt.count;
		else if (left_reg != 4'h0)
			left_next = left_reg - 4'h1;
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			left_reg <= 4'h0;
		else
			left_reg <= left_next;
	end
	assign cnt.done = (left_reg == 4'h1) && !cnt.load;
endmodule : aesa_timer
`default_nettype wire

// ===== verification/aesa_ctrl_monitor.sv
// Checker for the memory pin sequencing of aesa_ctrl.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module aesa_ctrl_monitor
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        o_done,
	input  wire logic        o_chip_select_low_active,
	input  wire logic        o_chip_select_high_active,
	input  wire logic        o_oe_n,
	input  wire logic        o_we_n,
	input  wire logic        o_lower_lane_enable_n,
	input  wire logic        o_upper_lane_enable_n,
	input  wire logic [19:0] o_addr,
	input  wire logic        o_dq_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire logic sel = !o_chip_select_low_active && o_chip_select_high_active;
	wire logic any_lane = !(o_lower_lane_enable_n && o_upper_lane_enable_n);
	property p_sel_pair; o_chip_select_high_active == !o_chip_select_low_active; endproperty
	a_sel_pair: assert property (p_sel_pair) else $error("select pins disagree");
	property p_wr_overlap; !o_we_n |-> sel && any_lane; endproperty
	a_wr_overlap: assert property (p_wr_overlap) else $error("write without overlap");
	// One-cycle write strobe; write enable rises while still selected
	property p_wr_end; $fell(o_we_n) |=> o_we_n && sel ##1 o_done; endproperty
	a_wr_end: assert property (p_wr_end) else $error("write strobe timing wrong");
	property p_rd_we; !o_oe_n |-> o_we_n && sel; endproperty
	a_rd_we: assert property (p_rd_we) else $error("write enable low in read");
	property p_addr_setup; $fell(o_chip_select_low_active) |-> $stable(o_addr); endproperty
	a_addr_setup: assert property (p_addr_setup) else $error("address moved at select");
	property p_no_clash; !o_oe_n |-> o_dq_oe_n; endproperty
	a_no_clash: assert property (p_no_clash) else $error("data driven during read");
	property p_rd_len; $fell(o_oe_n) |-> !o_oe_n [*2] ##1 o_oe_n ##1 o_done; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read strobe timing wrong");
	property p_rd_lane; !o_oe_n |-> any_lane; endproperty
	a_rd_lane: assert property (p_rd_lane) else $error("read with no lane");
	property p_drv_sel; !o_dq_oe_n |-> sel; endproperty
	a_drv_sel: assert property (p_drv_sel) else $error("data driven while idle");
	c_rd: cover property ($fell(o_oe_n) ##3 o_done);
	c_wr: cover property ($fell(o_we_n) ##2 o_done);
	c_lane: cover property (!o_we_n && o_upper_lane_enable_n);
endmodule : aesa_ctrl_monitor
bind aesa_ctrl aesa_ctrl_monitor u_mon (.*);
`default_nettype wire

// ===== verification/aesa_mem_model.sv
// Behavioural model of the asynchronous ECC static memory.
// Assumes pins are updated just after the controller clock edge.
`timescale 1ns/1ps
`default_nettype none
module aesa_mem_model
(
	input  wire logic        i_clk,
	input  wire logic        i_cs_n,
	input  wire logic        i_cs_hi,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_le_n,
	input  wire logic        i_ue_n,
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_inj,
	output logic      [15:0] o_dq,
	output logic             o_err
);
	logic [15:0] mem [0:255];
	logic        sel;
	logic        rd;
	assign sel = !i_cs_n && i_cs_hi;
	assign rd = sel && !i_oe_n && i_we_n;
	// Floating lanes show the inverse so a stale value never passes
	assign o_dq[7:0] = (rd && !i_le_n) ? mem[i_addr[7:0]][7:0] : ~mem[i_addr[7:0]][7:0];
	assign o_dq[15:8] = (rd && !i_ue_n) ? mem[i_addr[7:0]][15:8] : ~mem[i_addr[7:0]][15:8];
	// Floating flag shows the inverse so a badly timed sample is caught
	assign o_err = (rd && !(i_le_n && i_ue_n)) ? i_inj : !i_inj;
	initial
	begin
		for (int k = 0; k < 256; k++) mem[k] = 16'h0000;
	end
	always @(posedge i_clk)
	begin
		if (sel && !i_we_n && !i_le_n) mem[i_addr[7:0]][7:0] <= i_dq[7:0];
		if (sel && !i_we_n && !i_ue_n) mem[i_addr[7:0]][15:8] <= i_dq[15:8];
	end
endmodule : aesa_mem_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for aesa_ctrl against the memory model.
// Assumes a 100 MHz clock and reset held for three cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import aesa_pkg::*;
	logic i_clk, i_rst, i_req, i_we, inj, o_busy, o_done, o_err, i_err, o_dq_oe_n;
	logic o_chip_select_low_active, o_chip_select_high_active, o_oe_n, o_we_n;
	logic o_lower_lane_enable_n, o_upper_lane_enable_n;
	logic [19:0] i_addr, o_addr;
	logic [15:0] i_wdata, o_rdata, o_dq, i_dq;
	aesa_lanes_type i_lanes;
	int bad_count, check_count;
	aesa_ctrl uut (.i_clk, .i_rst, .i_req, .i_we, .i_addr, .i_wdata, .i_lanes, .o_busy,
		.o_done, .o_rdata, .o_err, .o_chip_select_low_active, .o_chip_select_high_active,
		.o_oe_n, .o_we_n, .o_lower_lane_enable_n, .o_upper_lane_enable_n, .o_addr, .o_dq,
		.o_dq_oe_n, .i_dq, .i_err);
	aesa_mem_model mem (.i_clk(i_clk), .i_cs_n(o_chip_select_low_active),
		.i_cs_hi(o_chip_select_high_active), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
		.i_le_n(o_lower_lane_enable_n), .i_ue_n(o_upper_lane_enable_n), .i_addr(o_addr),
		.i_dq(o_dq), .i_inj(inj), .o_dq(i_dq), .o_err(i_err));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			$display("Error %0t %s got %h", $time, m, got);
			bad_count++;
		end
	endtask : chk
	task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d,
		input aesa_lanes_type l);
		int n;
		@(posedge i_clk);
		i_req <= 1'b1; i_we <= w; i_addr <= a; i_wdata <= d; i_lanes <= l;
		@(posedge i_clk);
		i_req <= 1'b0;
		n = 0;
		do
		begin
			@(posedge i_clk);
			#1 n++;
		end while (o_done !== 1'b1 && n < 20);
		chk({15'h0, o_done}, 16'h0001, "no completion");
	endtask : acc
	task automatic t_word;
		acc(1'b1, 20'h00012, 16'hA5C3, 2'h3);
		acc(1'b0, 20'h00012, 16'h0000, 2'h3);
		chk(o_rdata, 16'hA5C3, "word read");
		chk({15'h0, o_err}, 16'h0000, "flag on clean read");
		$display("t_word done");
	endtask : t_word
	task automatic t_lane;
		acc(1'b1, 20'h00012, 16'h1234, 2'h1);
		acc(1'b0, 20'h00012, 16'h0000, 2'h3);
		chk(o_rdata, 16'hA534, "lower lane write");
		acc(1'b0, 20'h00012, 16'h0000, 2'h2);
		chk(o_rdata, 16'hA500, "upper lane read");
		acc(1'b1, 20'h00012, 16'h5600, 2'h2);
		acc(1'b0, 20'h00012, 16'h0000, 2'h3);
		chk(o_rdata, 16'h5634, "upper lane write");
		$display("t_lane done");
	endtask : t_lane
	task automatic t_err;
		inj = 1'b1;
		acc(1'b0, 20'h00012, 16'h0000, 2'h1);
		chk({15'h0, o_err}, 16'h0001, "flag on corrected read");
		chk(o_rdata, 16'h0034, "lower lane read");
		inj = 1'b0;
		acc(1'b1, 20'h00020, 16'h00FF, 2'h3);
		chk({15'h0, o_err}, 16'h0000, "flag after write");
		$display("t_err done");
	endtask : t_err
	task automatic t_refuse;
		@(posedge i_clk);
		i_req <= 1'b1; i_we <= 1'b1; i_lanes <= 2'h0;
		@(posedge i_clk);
		i_req <= 1'b0;
		#1 chk({15'h0, o_busy}, 16'h0000, "no-lane request taken");
		repeat (3) @(posedge i_clk);
		#1 chk({15'h0, o_chip_select_low_active}, 16'h0001, "select on refused request");
		$display("t_refuse done");
	endtask : t_refuse
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		#20000;
		bad_count++;
		results();
	end
	initial
	begin
		i_rst = 1'b1; i_req = 1'b0; i_we = 1'b0; i_addr = 20'h0; i_wdata = 16'h0;
		i_lanes = 2'h0; inj = 1'b0; bad_count = 0; check_count = 0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		t_word();
		t_lane();
		t_err();
		t_refuse();
		results();
	end
endmodule : testbench
`default_nettype wire
